// File: mfg_pkg.sv
/*
  Package for the multi-function general pin bank: function codes, pin
  count, blink timing and the packed structs that carry pin and status
  groups. Assumes a 25 MHz module clock.
*/
package mfg_pkg;

  // ---------------------------------------------------------------
  // Sizes and clock
  // ---------------------------------------------------------------
  localparam int unsigned NPINS      = 14;
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned TICK_CYC   = CLK_HZ / 1000 * TICK_MS;

  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FN_OUT      = 8'h00;
  localparam logic [7:0] FN_IN       = 8'h01;
  localparam logic [7:0] FN_NETSTAT  = 8'h02;
  localparam logic [7:0] FN_SUPPLY   = 8'h03;
  localparam logic [7:0] FN_DREADY   = 8'h04;
  localparam logic [7:0] FN_RTCSHARE = 8'h05;
  localparam logic [7:0] FN_CARDDET  = 8'h07;
  localparam logic [7:0] FN_TXBURST  = 8'h09;
  localparam logic [7:0] FN_PWRIND   = 8'h0A;
  localparam logic [7:0] FN_ACTIND   = 8'h0B;
  localparam logic [7:0] FN_AUDIO    = 8'h0C;
  localparam logic [7:0] FN_SPI      = 8'h0D;
  localparam logic [7:0] FN_DISABLED = 8'hFF;

  // ---------------------------------------------------------------
  // Blink phase lengths in ms
  // ---------------------------------------------------------------
  localparam logic [11:0] MS_50      = 12'h032;
  localparam logic [11:0] MS_100     = 12'h064;
  localparam logic [11:0] MS_2000    = 12'h7D0;

  // ---------------------------------------------------------------
  // Network status categories
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    NET_NONE    = 3'h0,
    NET_HOME2G  = 3'h1,
    NET_HOME3G  = 3'h2,
    NET_VISIT2G = 3'h3,
    NET_VISIT3G = 3'h4,
    NET_CALL    = 3'h5
  } mfg_net_t;

  // Pad drive for the whole bank
  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pd;
    logic [NPINS-1:0] pu;
  } mfg_pad_t;

  // Module status inputs
  typedef struct packed {
    mfg_net_t net;
    logic     power_on;
    logic     active;
  } mfg_stat_t;

  // Per-pin special-function drive and direction requests
  typedef struct packed {
    logic [NPINS-1:0] val;
    logic [NPINS-1:0] oe;
  } mfg_fdrv_t;

endpackage

// File: mfg_blink.sv
/*
  Network status blink sequencer. Times its phases from a 1 ms enable
  pulse and restarts at the first high phase when the category changes.
  Assumes i_tick_ms is a one-cycle pulse in the i_clk domain.
*/
`timescale 1ns/1ns
module mfg_blink
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // Time base and category
  input  wire logic            i_tick_ms,
  input  wire mfg_pkg::mfg_net_t i_net,
  // Blink level
  output logic                 o_level
);

  typedef enum logic [3:0] {
    PH_H1 = 4'h1,
    PH_L1 = 4'h2,
    PH_H2 = 4'h4,
    PH_LL = 4'h8
  } mfg_ph_t;

  mfg_ph_t            ph_ff;
  mfg_ph_t            nxt_ph;
  logic [11:0]        cnt_ff;
  mfg_pkg::mfg_net_t  net_ff;
  logic [11:0]        hi_len;
  logic [11:0]        gap_len;
  logic [11:0]        low_len;
  logic               two_pulse;
  logic [11:0]        ph_len;
  logic               ph_done;
  logic               changed;
  logic               level;

  // ---------------------------------------------------------------
  // Pattern table
  // ---------------------------------------------------------------
  assign hi_len    = (i_net == mfg_pkg::NET_HOME2G ||
                      i_net == mfg_pkg::NET_VISIT2G) ?
                     mfg_pkg::MS_100 : mfg_pkg::MS_50;
  assign gap_len   = hi_len;
  assign low_len   = (i_net == mfg_pkg::NET_VISIT3G) ?
                     mfg_pkg::MS_100 : mfg_pkg::MS_2000;
  assign two_pulse = (i_net != mfg_pkg::NET_HOME2G);
  assign ph_len    = (ph_ff == PH_LL) ? low_len :
                     (ph_ff == PH_L1) ? gap_len : hi_len;
  assign ph_done   = i_tick_ms && (cnt_ff >= ph_len - 12'h001);
  assign changed   = (net_ff != i_net);

  always_comb
  begin
    nxt_ph = ph_ff;
    unique case (ph_ff)
      PH_H1: nxt_ph = two_pulse ? PH_L1 : PH_LL;
      PH_L1: nxt_ph = PH_H2;
      PH_H2: nxt_ph = PH_LL;
      PH_LL: nxt_ph = PH_H1;
      default: nxt_ph = PH_H1;
    endcase
  end

  // Call forces high, no service forces low; blink otherwise
  assign level = (i_net == mfg_pkg::NET_CALL) ? 1'b1 :
                 (i_net == mfg_pkg::NET_NONE) ? 1'b0 :
                 (ph_ff == PH_H1 || ph_ff == PH_H2);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ph_ff   <= PH_H1;
      cnt_ff  <= 12'h000;
      net_ff  <= mfg_pkg::NET_NONE;
      o_level <= 1'b0;
    end
    else
    begin
      net_ff  <= i_net;
      o_level <= level;
      if (changed)
      begin
        ph_ff  <= PH_H1;
        cnt_ff <= 12'h000;
      end
      else if (ph_done)
      begin
        ph_ff  <= nxt_ph;
        cnt_ff <= 12'h000;
      end
      else if (i_tick_ms)
        cnt_ff <= cnt_ff + 12'h001;
    end
  end

endmodule // mfg_blink

// File: mfg_pins.sv
/*
  Multi-function general pin bank: fourteen pins, each steered by an
  8-bit function code. Holds per-pin defaults, refuses codes a pin does
  not list, and drives pads from plain outputs, the blink sequencer,
  power and activity status, or the audio/SPI engines outside.
  Assumes all inputs are synchronous to i_clk (25 MHz).
*/
`timescale 1ns/1ns

// Behaviour
// - No service: status pin held low
// - Home 2G: high 100 ms, low 2 s
// - Home 3G: 50 high/low/high, low 2 s
// - Visitor 2G: 100 high/low/high, low 2 s
// - Visitor 3G: 50 high/low/high, low 100 ms
// - Call active: status pin held high
// - Code 10 power indicator, pin 1/13, single
// - Code 11 activity indicator, pin 14/5, single
// - Code 12 audio port on pins 6-9 only
// - Code 13 SPI on pins 10-14 only
// - Code 1 input, level readable
// - Code 0 output drives written value
// - Code 255 tri-state with pull-down
// - Reset defaults for pins 1 to 5
// - Only listed alternatives accepted per pin
// - Audio pins directions, may be output/input/disabled
// - SPI clock input, idles low, pull-down
// - MOSI input, idles high, pull-up
// - Code 2 status on one pin 1-5
module mfg_pins
#(
  parameter int unsigned NP       = mfg_pkg::NPINS,
  // Clock cycles per millisecond tick
  parameter int unsigned TICK_CYC = mfg_pkg::TICK_CYC
)
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // Function configuration write
  input  wire logic                 i_cfg_we,
  input  wire logic [3:0]           i_cfg_pin,
  input  wire logic [7:0]           i_cfg_code,
  // Level write
  input  wire logic                 i_lvl_we,
  input  wire logic [3:0]           i_lvl_pin,
  input  wire logic                 i_lvl_val,
  // Module status
  input  wire mfg_pkg::mfg_stat_t   i_stat,
  input  wire logic                 i_supply_en,
  input  wire logic                 i_tx_burst,
  input  wire logic                 i_rtc_sync,
  // Special-function engines (audio, SPI) per pin
  input  wire mfg_pkg::mfg_fdrv_t   i_eng,
  // Pads
  input  wire logic [NP-1:0]        i_pad,
  output mfg_pkg::mfg_pad_t         o_pad,
  // Readback
  output logic [NP-1:0]             o_in_level,
  output logic [NP-1:0]             o_pad_in,
  output logic                      o_cfg_ack,
  output logic                      o_cfg_nak,
  output logic [7:0]                o_cfg_code
);

  logic [7:0]         fn_ff [NP];
  logic [NP-1:0]      outv_ff;
  logic [NP-1:0]      in_ff;
  logic [NP-1:0]      pad_in_ff;
  mfg_pkg::mfg_pad_t  pad_ff;
  mfg_pkg::mfg_pad_t  nxt_pad;
  logic               ack_ff;
  logic               nak_ff;
  logic [7:0]         rdcode_ff;
  logic [15:0]        tick_cnt_ff;
  logic               tick_ff;
  logic               blink;
  logic               cfg_ok;
  logic               pin_ok;
  logic               held_else;
  logic [NP-1:0]      code_hits;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Default code for pin index p (0 based)
  function automatic logic [7:0] dflt(input int unsigned p);
    if (p == 0)
      dflt = mfg_pkg::FN_DISABLED;
    else if (p == 1)
      dflt = mfg_pkg::FN_SUPPLY;
    else if (p == 2)
      dflt = mfg_pkg::FN_DREADY;
    else if (p == 3)
      dflt = mfg_pkg::FN_RTCSHARE;
    else if (p == 4)
      dflt = mfg_pkg::FN_CARDDET;
    else if (p <= 8)
      dflt = mfg_pkg::FN_AUDIO;
    else
      dflt = mfg_pkg::FN_SPI;
  endfunction

  // Whether pin index p lists code c
  function automatic logic allowed(input logic [3:0] p,
                                   input logic [7:0] c);
    logic gen;
    gen = (c == mfg_pkg::FN_OUT) || (c == mfg_pkg::FN_IN) ||
          (c == mfg_pkg::FN_DISABLED);
    allowed = 1'b0;
    if (c == dflt(int'(p)))
      allowed = 1'b1;
    else if (p == 4'h0)
      allowed = (c == mfg_pkg::FN_OUT) || (c == mfg_pkg::FN_IN) ||
                (c == mfg_pkg::FN_NETSTAT) ||
                (c == mfg_pkg::FN_SUPPLY) ||
                (c == mfg_pkg::FN_TXBURST) ||
                (c == mfg_pkg::FN_PWRIND);
    else if (p <= 4'h4)
      allowed = gen || (c == mfg_pkg::FN_NETSTAT) ||
                (c == mfg_pkg::FN_SUPPLY && p != 4'h1) ||
                (c == mfg_pkg::FN_ACTIND && p == 4'h4);
    else if (p == 4'hC)
      allowed = gen || (c == mfg_pkg::FN_PWRIND);
    else if (p == 4'hD)
      allowed = gen || (c == mfg_pkg::FN_ACTIND);
    else if (p < 4'(NP))
      allowed = gen;
  endfunction

  // Single-holder functions
  function automatic logic exclusive(input logic [7:0] c);
    exclusive = (c == mfg_pkg::FN_NETSTAT) ||
                (c == mfg_pkg::FN_SUPPLY) ||
                (c == mfg_pkg::FN_PWRIND) ||
                (c == mfg_pkg::FN_ACTIND);
  endfunction

  // ---------------------------------------------------------------
  // Configuration checks
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < NP; g++)
    begin : g_hit
      assign code_hits[g] = (fn_ff[g] == i_cfg_code) &&
                            (4'(g) != i_cfg_pin);
    end
  endgenerate

  assign pin_ok    = (i_cfg_pin < 4'(NP)) &&
                     allowed(i_cfg_pin, i_cfg_code);
  assign held_else = exclusive(i_cfg_code) && (|code_hits);
  assign cfg_ok    = pin_ok && !held_else;

  // ---------------------------------------------------------------
  // Millisecond time base
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_ff <= 16'h0000;
      tick_ff     <= 1'b0;
    end
    else
    begin
      tick_ff <= (tick_cnt_ff == 16'(TICK_CYC - 1));
      if (tick_cnt_ff == 16'(TICK_CYC - 1))
        tick_cnt_ff <= 16'h0000;
      else
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end

  mfg_blink u_blink
  (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_tick_ms (tick_ff),
    .i_net     (i_stat.net),
    .o_level   (blink)
  );

  // ---------------------------------------------------------------
  // Pad steering
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_pad = '0;
    for (int p = 0; p < NP; p++)
    begin
      unique case (fn_ff[p])
        mfg_pkg::FN_OUT:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = outv_ff[p];
        end
        mfg_pkg::FN_IN: ;
        mfg_pkg::FN_NETSTAT:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = blink;
        end
        mfg_pkg::FN_SUPPLY:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = i_supply_en;
        end
        mfg_pkg::FN_DREADY, mfg_pkg::FN_CARDDET:
          nxt_pad.pd[p]  = 1'b1;
        mfg_pkg::FN_RTCSHARE:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = i_rtc_sync;
        end
        mfg_pkg::FN_TXBURST:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = i_tx_burst;
        end
        mfg_pkg::FN_PWRIND:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = i_stat.power_on;
        end
        mfg_pkg::FN_ACTIND:
        begin
          nxt_pad.oe[p]  = 1'b1;
          nxt_pad.out[p] = i_stat.active;
        end
        mfg_pkg::FN_AUDIO:
        begin
          // Rx data input, Tx data output, clocks per engine
          nxt_pad.oe[p]  = (p == 5) ? 1'b0 :
                           (p == 6) ? 1'b1 : i_eng.oe[p];
          nxt_pad.out[p] = i_eng.val[p];
        end
        mfg_pkg::FN_SPI:
        begin
          nxt_pad.oe[p]  = (p == 11 || p == 12) ? 1'b1 : 1'b0;
          nxt_pad.out[p] = i_eng.val[p];
          nxt_pad.pd[p]  = (p == 9 || p == 13);
          nxt_pad.pu[p]  = (p == 10);
        end
        default:
          nxt_pad.pd[p]  = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int p = 0; p < NP; p++)
        fn_ff[p] <= dflt(p);
      outv_ff   <= '0;
      ack_ff    <= 1'b0;
      nak_ff    <= 1'b0;
      rdcode_ff <= 8'h00;
    end
    else
    begin
      ack_ff <= i_cfg_we && cfg_ok;
      nak_ff <= i_cfg_we && !cfg_ok;
      if (i_cfg_we && cfg_ok)
        fn_ff[i_cfg_pin] <= i_cfg_code;
      if (i_lvl_we && i_lvl_pin < 4'(NP))
        outv_ff[i_lvl_pin] <= i_lvl_val;
      if (i_cfg_pin < 4'(NP))
        rdcode_ff <= fn_ff[i_cfg_pin];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pad_ff    <= '0;
      in_ff     <= '0;
      pad_in_ff <= '0;
    end
    else
    begin
      pad_ff    <= nxt_pad;
      pad_in_ff <= i_pad;
      for (int p = 0; p < NP; p++)
        if (fn_ff[p] == mfg_pkg::FN_IN)
          in_ff[p] <= i_pad[p];
        else
          in_ff[p] <= 1'b0;
    end
  end

  assign o_pad      = pad_ff;
  assign o_in_level = in_ff;
  assign o_pad_in   = pad_in_ff;
  assign o_cfg_ack  = ack_ff;
  assign o_cfg_nak  = nak_ff;
  assign o_cfg_code = rdcode_ff;

endmodule // mfg_pins

// File: mfg_pins_properties.sv
/* Checker for the pin bank ports.
   Bound to mfg_pins from the testbench; sees ports only. */
`timescale 1ns/1ns
module mfg_pins_properties
#(
  parameter int unsigned NP = 14
)
(
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic               i_cfg_we,
  input wire logic [3:0]         i_cfg_pin,
  input wire logic [7:0]         i_cfg_code,
  input wire logic               i_lvl_we,
  input wire logic [3:0]         i_lvl_pin,
  input wire logic               i_lvl_val,
  input wire mfg_pkg::mfg_stat_t i_stat,
  input wire logic               i_supply_en,
  input wire logic               i_tx_burst,
  input wire logic               i_rtc_sync,
  input wire mfg_pkg::mfg_fdrv_t i_eng,
  input wire logic [NP-1:0]      i_pad,
  input wire mfg_pkg::mfg_pad_t  o_pad,
  input wire logic [NP-1:0]      o_in_level,
  input wire logic [NP-1:0]      o_pad_in,
  input wire logic               o_cfg_ack,
  input wire logic               o_cfg_nak,
  input wire logic [7:0]         o_cfg_code
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Accepted disable request, seen over its two steps
  sequence s_dis_ok;
    i_cfg_we && i_cfg_code == 8'hFF ##1 o_cfg_ack;
  endsequence

  a_one_answer: assert property (
    i_cfg_we |=> o_cfg_ack != o_cfg_nak)
    else $error("config write not answered once");
  a_bad_index: assert property (
    i_cfg_we && i_cfg_pin > 4'hD |=> o_cfg_nak)
    else $error("pin index out of range accepted");
  a_audio_only: assert property (
    i_cfg_we && i_cfg_code == 8'h0C
    && (i_cfg_pin < 4'h5 || i_cfg_pin > 4'h8) |=> o_cfg_nak)
    else $error("audio code accepted off its pins");
  a_spi_only: assert property (
    i_cfg_we && i_cfg_code == 8'h0D && i_cfg_pin < 4'h9 |=> o_cfg_nak)
    else $error("serial code accepted off its pins");
  a_pwr_pins: assert property (
    i_cfg_we && i_cfg_code == 8'h0A && i_cfg_pin != 4'h0
    && i_cfg_pin != 4'hC |=> o_cfg_nak)
    else $error("power indicator accepted off its pins");
  a_act_pins: assert property (
    i_cfg_we && i_cfg_code == 8'h0B && i_cfg_pin != 4'hD
    && i_cfg_pin != 4'h4 |=> o_cfg_nak)
    else $error("activity indicator accepted off its pins");
  a_net_pins: assert property (
    i_cfg_we && i_cfg_code == 8'h02 && i_cfg_pin > 4'h4 |=> o_cfg_nak)
    else $error("status code accepted off pins 1-5");
  a_dis_pull: assert property (
    s_dis_ok |=> o_pad.pd[$past(i_cfg_pin, 2)]
    && !o_pad.oe[$past(i_cfg_pin, 2)])
    else $error("disabled pin not floating with pull-down");
  a_reset_dflt: assert property (
    $rose(i_rst_n) |=> o_pad.pd[0] && !o_pad.oe[0] && o_pad.oe[1]
    && o_pad.pd[2] && o_pad.oe[3] && o_pad.pd[4] && !o_pad.oe[5]
    && o_pad.oe[6] && o_pad.pd[9] && !o_pad.oe[9] && o_pad.pu[10])
    else $error("pad defaults wrong after reset");
  a_in_src: assert property (
    (o_in_level & ~$past(i_pad)) == '0)
    else $error("input level high without pad high");
endmodule // mfg_pins_properties

// File: mfg_far_end.sv
/* Far side of every pad: processor pin or LED driver.
   Resolves the level seen by the bank from both drives and pulls. */
`timescale 1ns/1ns
module mfg_far_end
(
  // Clock
  input  wire logic              i_clk,
  // Bank drive and far-side drive
  input  wire mfg_pkg::mfg_pad_t i_pad_drv,
  input  wire logic [13:0]       i_ext_val,
  input  wire logic [13:0]       i_ext_oe,
  // Resolved level
  output logic [13:0]            o_level
);
  logic [13:0] last_ff;

  // A floating pad with no pull flips each cycle, so a stale level
  // never passes for a driven one
  always_comb
  begin
    for (int i = 0; i < 14; i++)
    begin
      if (i_pad_drv.oe[i])
        o_level[i] = i_pad_drv.out[i];
      else if (i_ext_oe[i])
        o_level[i] = i_ext_val[i];
      else if (i_pad_drv.pu[i])
        o_level[i] = 1'b1;
      else if (i_pad_drv.pd[i])
        o_level[i] = 1'b0;
      else
        o_level[i] = ~last_ff[i];
    end
  end

  initial last_ff = 14'h0000;
  always @(posedge i_clk) last_ff <= o_level;
endmodule // mfg_far_end

// File: mfg_pins_tb.sv
/* Self-checking bench for the pin bank.
   Drives config, level and status ports; far side from mfg_far_end. */
`timescale 1ns/1ns
module mfg_pins_tb;
  logic               i_clk, i_rst_n, i_cfg_we, i_lvl_we, i_lvl_val;
  logic               i_supply_en, i_tx_burst, o_cfg_ack, o_cfg_nak;
  logic [3:0]         i_cfg_pin, i_lvl_pin;
  logic [7:0]         i_cfg_code, o_cfg_code;
  logic [13:0]        i_pad, ext_val, ext_oe, o_in_level;
  mfg_pkg::mfg_stat_t i_stat;
  mfg_pkg::mfg_pad_t  o_pad;
  int                 err_count, compares;
  int                 run;
  logic [13:0]        pad_in;
  mfg_pkg::mfg_fdrv_t eng;
  // Short tick so whole blink cycles fit inside the run
  localparam int      TK = 4;
  // High phase and long low phase per category, in ms
  logic [11:0]        hi_ms [1:4] = '{mfg_pkg::MS_100, mfg_pkg::MS_50,
                                      mfg_pkg::MS_100, mfg_pkg::MS_50};
  logic [11:0]        lo_ms [1:4] = '{mfg_pkg::MS_2000, mfg_pkg::MS_2000,
                                      mfg_pkg::MS_2000, mfg_pkg::MS_100};
  // Refused requests as {pin index, code}
  logic [11:0]        bad [8] = '{12'h40C, 12'h00D, 12'h10A, 12'h00B,
                                  12'h502, 12'hE00, 12'h109, 12'h2FE};

  mfg_pins #(.TICK_CYC(TK)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cfg_we(i_cfg_we),
    .i_cfg_pin(i_cfg_pin), .i_cfg_code(i_cfg_code), .i_lvl_we(i_lvl_we),
    .i_lvl_pin(i_lvl_pin), .i_lvl_val(i_lvl_val), .i_stat(i_stat),
    .i_supply_en(i_supply_en), .i_tx_burst(i_tx_burst),
    .i_rtc_sync(1'b0), .i_eng(eng), .i_pad(i_pad), .o_pad(o_pad),
    .o_in_level(o_in_level), .o_pad_in(pad_in), .o_cfg_ack(o_cfg_ack),
    .o_cfg_nak(o_cfg_nak), .o_cfg_code(o_cfg_code));
  mfg_far_end FAR (.i_clk(i_clk), .i_pad_drv(o_pad),
    .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(i_pad));

  // ----------------------------
  // Access tasks
  // ----------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  task automatic wrap_up();
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Answer is {ack, nak} one cycle on; pads settle one cycle later
  task automatic cfg(input logic [3:0] pin, input logic [7:0] code,
                     input logic [1:0] exp);
    i_cfg_we = 1'b1;
    i_cfg_pin = pin;
    i_cfg_code = code;
    tick(1);
    i_cfg_we = 1'b0;
    check({o_cfg_ack, o_cfg_nak}, exp);
    tick(2);
  endtask
  task automatic lvl(input logic [3:0] pin, input logic val);
    i_lvl_we = 1'b1;
    i_lvl_pin = pin;
    i_lvl_val = val;
    tick(1);
    i_lvl_we = 1'b0;
    tick(2);
  endtask
  // Status-driven pins have no fixed latency, so wait with a bound
  task automatic wait_out(input int idx, input logic exp);
    int n;
    n = 0;
    while (o_pad.out[idx] !== exp && n < 16)
    begin
      tick(1);
      n++;
    end
    check({o_pad.oe[idx], o_pad.out[idx]}, {1'b1, exp});
    if (n == 16)
      wrap_up();
  endtask
  // Cycles the status pin holds level lv, bounded
  task automatic run_len(input logic lv, output int n);
    n = 0;
    while (o_pad.out[0] === lv && n < 9000)
    begin
      tick(1);
      n++;
    end
    if (n == 9000)
    begin
      err_count++;
      wrap_up();
    end
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial
  begin
    #4_000_000;
    err_count++;
    wrap_up();
  end

  // ----------------------------
  // Scenarios
  // ----------------------------
  initial
  begin
    {i_rst_n, i_cfg_we, i_lvl_we, i_lvl_val, i_tx_burst} = '0;
    {i_cfg_pin, i_lvl_pin, i_cfg_code, ext_val, ext_oe} = '0;
    i_stat = '0;
    eng = '0;
    i_supply_en = 1'b1;
    tick(16);
    i_rst_n = 1'b1;
    tick(2);
    check(o_pad.oe, 16'h184A);
    check(o_pad.pd & 14'h2215, 16'h2215);
    check({o_pad.pu[10], o_pad.out[1]}, 2'b11);
    check(o_cfg_code, mfg_pkg::FN_DISABLED);
    eng.oe[8:7] = 2'b11;
    eng.val[8:7] = 2'b01;
    tick(2);
    check({o_pad.oe[8:7], o_pad.out[8:7]}, 4'hD);
    foreach (bad[i]) cfg(bad[i][11:8], bad[i][7:0], 2'b01);
    cfg(4'h2, 8'h00, 2'b10);
    check(o_cfg_code, mfg_pkg::FN_OUT);
    lvl(4'h2, 1'b1);
    check({o_pad.oe[2], o_pad.out[2]}, 2'b11);
    lvl(4'h2, 1'b0);
    check({o_pad.oe[2], o_pad.out[2]}, 2'b10);
    cfg(4'h6, 8'h01, 2'b10);
    ext_oe[6] = 1'b1;
    for (int v = 1; v >= 0; v--)
    begin
      ext_val[6] = v[0];
      tick(2);
      check({o_pad.oe[6], o_in_level[6], pad_in[6]},
            {1'b0, v[0], v[0]});
    end
    cfg(4'h4, 8'hFF, 2'b10);
    check({o_pad.oe[4], o_pad.pd[4]}, 2'b01);
    cfg(4'h5, 8'hFF, 2'b10);
    cfg(4'hC, 8'h0A, 2'b10);
    cfg(4'h0, 8'h0A, 2'b01);
    cfg(4'hD, 8'h0B, 2'b10);
    cfg(4'h4, 8'h0B, 2'b01);
    for (int v = 1; v >= 0; v--)
    begin
      i_stat.power_on = v[0];
      i_stat.active = v[0];
      wait_out(12, v[0]);
      wait_out(13, v[0]);
    end
    cfg(4'h0, 8'h09, 2'b10);
    i_tx_burst = 1'b1;
    wait_out(0, 1'b1);
    cfg(4'h0, 8'h02, 2'b10);
    cfg(4'h3, 8'h02, 2'b01);
    i_stat.net = mfg_pkg::NET_CALL;
    wait_out(0, 1'b1);
    for (int c = 1; c < 5; c++)
    begin
      i_stat.net = mfg_pkg::NET_NONE;
      wait_out(0, 1'b0);
      i_stat.net = mfg_pkg::mfg_net_t'(c[2:0]);
      wait_out(0, 1'b1);
      tick(100);
      check(o_pad.out[0], 1'b1);
      // First high phase is partly spent by the wait_out and tick(100) waits; measure later ones
      run_len(1'b1, run);
      if (c > 1)
      begin
        run_len(1'b0, run);
        check(16'(run), 16'(hi_ms[c] * TK));
        run_len(1'b1, run);
        check(16'(run), 16'(hi_ms[c] * TK));
      end
      run_len(1'b0, run);
      check(16'(run), 16'(lo_ms[c] * TK));
      run_len(1'b1, run);
      check(16'(run), 16'(hi_ms[c] * TK));
    end
    wrap_up();
  end
endmodule // mfg_pins_tb

bind mfg_pins mfg_pins_properties #(.NP(NP)) PROPS (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_cfg_we(i_cfg_we), .i_cfg_pin(i_cfg_pin),
  .i_cfg_code(i_cfg_code), .i_lvl_we(i_lvl_we), .i_lvl_pin(i_lvl_pin),
  .i_lvl_val(i_lvl_val), .i_stat(i_stat), .i_supply_en(i_supply_en),
  .i_tx_burst(i_tx_burst), .i_rtc_sync(i_rtc_sync), .i_eng(i_eng),
  .i_pad(i_pad), .o_pad(o_pad), .o_in_level(o_in_level),
  .o_pad_in(o_pad_in), .o_cfg_ack(o_cfg_ack), .o_cfg_nak(o_cfg_nak),
  .o_cfg_code(o_cfg_code));
